// ==== hdl/jtag_tap.sv ====
/*
  Boundary-scan test access port: TAP controller, instruction register,
  bypass, identification and boundary-scan data registers, pin muxing.
  Assumes tck/tms/tdi/trst_n and the pin inputs are asynchronous to clk
  and that clk runs well above four times the tck rate.
*/
`timescale 1ns/1ns
// Overview of operation
// - Sixteen-state TAP machine advancing on rising tck, steered by tms.
// - Chip reset forces Test-Logic-Reset at power-up, no tester sequence needed.
// - Ports tck, tdi, tdo, tms and active-low asynchronous trst_n.
// - Scan chain covers every functional pin; TAP pins stay outside it.
// - Five-bit instruction register shifted via IR path selects data register.
// - Undefined instruction codes act exactly like bypass 11111.
// - EXTEST selects boundary register, drives pins from cells, captures inputs.
// - SAMPLE selects boundary register, captures and preloads, pins untouched.
// - HIGHZ floats all functional outputs and shifts through bypass.
// - CLAMP drives pins from boundary cells while shifting through bypass.
// - IDCODE selects the 32-bit identification register.
// - Bypass is a single shift stage between tdi and tdo.
// - Identification: version 31-28, part 27-12, maker 11-1, bit0 one.
// - Boundary cells capture pins and drivers in parallel on rising tck.
module jtag_tap
  import tap_pkg::*;
#(
  parameter int NUM_PINS = 8,
  parameter logic [ID_VERSION_W-1:0] ID_VERSION = 4'h0,  // Arbitrary value
  parameter logic [ID_PART_W-1:0] ID_PART = 16'h0000,    // Arbitrary value
  parameter logic [ID_MANUF_W-1:0] ID_MANUF = 11'h000    // Arbitrary value
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic trst_n,
  output logic tdo,
  output logic tdo_oe,
  input wire logic [NUM_PINS-1:0] core_out,
  input wire logic [NUM_PINS-1:0] core_oe,
  input wire logic [NUM_PINS-1:0] pin_in,
  output logic [NUM_PINS-1:0] pin_out,
  output logic [NUM_PINS-1:0] pin_oe,
  output logic [NUM_PINS-1:0] core_in,
  output logic int_scan_en,
  output logic memory_self_test_en,
  output logic private_phy_test_en
);

  localparam int NUM_CELLS = NUM_PINS * CELLS_PER_PIN;

  // Refused at elaboration: a chain with no pins has no cell to shift through
  if (NUM_PINS < 1) begin : g_bad_num_pins
    $error("NUM_PINS must be at least 1");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and tck edge detection

  tap_pins_s tap_meta_ff;
  tap_pins_s tap_sync_ff;
  logic tck_prev_ff;
  logic [NUM_PINS-1:0] pin_meta_ff;
  logic [NUM_PINS-1:0] pin_sync_ff;
  logic tck_rise;
  logic tck_fall;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tap_meta_ff <= '{tck: 1'b0, tms: 1'b1, tdi: 1'b1, trst_n: 1'b0};
      tap_sync_ff <= '{tck: 1'b0, tms: 1'b1, tdi: 1'b1, trst_n: 1'b0};
      tck_prev_ff <= 1'b0;
      pin_meta_ff <= '0;
      pin_sync_ff <= '0;
    end else if (ce) begin
      tap_meta_ff <= '{tck: tck, tms: tms, tdi: tdi, trst_n: trst_n};
      tap_sync_ff <= tap_meta_ff;
      tck_prev_ff <= tap_sync_ff.tck;
      pin_meta_ff <= pin_in;
      pin_sync_ff <= pin_meta_ff;
    end
  end

  // Edges derived from the synchronised copy only, never the first stage
  assign tck_rise = tap_sync_ff.tck & ~tck_prev_ff;
  assign tck_fall = ~tap_sync_ff.tck & tck_prev_ff;

  ////////////////////////////////////////////////////////////////////////////
  // TAP controller

  tap_state_e state_ff;
  tap_state_e nxt_state;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      TEST_LOGIC_RESET: nxt_state = tap_sync_ff.tms ? TEST_LOGIC_RESET : RUN_TEST_IDLE;
      RUN_TEST_IDLE: nxt_state = tap_sync_ff.tms ? SELECT_DR : RUN_TEST_IDLE;
      SELECT_DR: nxt_state = tap_sync_ff.tms ? SELECT_IR : CAPTURE_DR;
      CAPTURE_DR: nxt_state = tap_sync_ff.tms ? EXIT1_DR : SHIFT_DR;
      SHIFT_DR: nxt_state = tap_sync_ff.tms ? EXIT1_DR : SHIFT_DR;
      EXIT1_DR: nxt_state = tap_sync_ff.tms ? UPDATE_DR : PAUSE_DR;
      PAUSE_DR: nxt_state = tap_sync_ff.tms ? EXIT2_DR : PAUSE_DR;
      EXIT2_DR: nxt_state = tap_sync_ff.tms ? UPDATE_DR : SHIFT_DR;
      UPDATE_DR: nxt_state = tap_sync_ff.tms ? SELECT_DR : RUN_TEST_IDLE;
      SELECT_IR: nxt_state = tap_sync_ff.tms ? TEST_LOGIC_RESET : CAPTURE_IR;
      CAPTURE_IR: nxt_state = tap_sync_ff.tms ? EXIT1_IR : SHIFT_IR;
      SHIFT_IR: nxt_state = tap_sync_ff.tms ? EXIT1_IR : SHIFT_IR;
      EXIT1_IR: nxt_state = tap_sync_ff.tms ? UPDATE_IR : PAUSE_IR;
      PAUSE_IR: nxt_state = tap_sync_ff.tms ? EXIT2_IR : PAUSE_IR;
      EXIT2_IR: nxt_state = tap_sync_ff.tms ? UPDATE_IR : SHIFT_IR;
      UPDATE_IR: nxt_state = tap_sync_ff.tms ? SELECT_DR : RUN_TEST_IDLE;
      default: nxt_state = TEST_LOGIC_RESET;
    endcase
  end

  // Chip reset doubles as the test-logic power-on reset
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= TEST_LOGIC_RESET;
    end else if (ce) begin
      if (!tap_sync_ff.trst_n) begin
        state_ff <= TEST_LOGIC_RESET;
      end else if (tck_rise) begin
        state_ff <= nxt_state;
      end
    end
  end

  logic in_tlr;
  logic step;
  assign in_tlr = (state_ff == TEST_LOGIC_RESET) || !tap_sync_ff.trst_n;
  assign step = tck_rise && tap_sync_ff.trst_n;

  ////////////////////////////////////////////////////////////////////////////
  // Instruction register and decode

  logic [IR_WIDTH-1:0] ir_shift_ff;
  logic [IR_WIDTH-1:0] ir_ff;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ir_shift_ff <= IR_CAPTURE_VAL;
      ir_ff <= IR_RESET_VAL;
    end else if (ce) begin
      if (in_tlr) begin
        ir_ff <= IR_RESET_VAL;
      end else if (step) begin
        case (state_ff)
          CAPTURE_IR: ir_shift_ff <= IR_CAPTURE_VAL;
          SHIFT_IR: ir_shift_ff <= {tap_sync_ff.tdi, ir_shift_ff[IR_WIDTH-1:1]};
          UPDATE_IR: ir_ff <= ir_shift_ff;
          default: ir_shift_ff <= ir_shift_ff;
        endcase
      end
    end
  end

  dr_sel_e dr_sel;
  logic mode_drive;
  logic mode_highz;
  logic mode_extest;
  logic bsr_sel;

  always_comb begin
    dr_sel = SEL_BYPASS;
    mode_drive = 1'b0;
    mode_highz = 1'b0;
    mode_extest = 1'b0;
    if (ir_ff == OP_EXTEST) begin
      dr_sel = SEL_BOUNDARY;
      mode_drive = 1'b1;
      mode_extest = 1'b1;
    end else if (ir_ff == OP_SAMPLE) begin
      dr_sel = SEL_BOUNDARY;
    end else if (ir_ff == OP_HIGHZ) begin
      mode_highz = 1'b1;
    end else if (ir_ff == OP_CLAMP) begin
      mode_drive = 1'b1;
    end else if (ir_ff == OP_IDCODE) begin
      dr_sel = SEL_IDCODE;
    end
  end
  assign bsr_sel = (dr_sel == SEL_BOUNDARY);

  // Vendor modes shift through bypass; they only raise an enable to the core
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      int_scan_en <= 1'b0;
      memory_self_test_en <= 1'b0;
      private_phy_test_en <= 1'b0;
    end else if (ce) begin
      int_scan_en <= (ir_ff == OP_INT_SCAN);
      memory_self_test_en <= (ir_ff == OP_MEMORY_SELF_TEST);
      private_phy_test_en <= (ir_ff == OP_PRIVATE_PHY_TEST);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bypass and identification registers

  logic bypass_ff;
  logic [ID_WIDTH-1:0] id_shift_ff;
  logic [ID_WIDTH-1:0] id_value;
  assign id_value = {ID_VERSION, ID_PART, ID_MANUF, ID_FIXED_BIT};

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bypass_ff <= 1'b0;
      id_shift_ff <= '0;
    end else if (ce && step) begin
      if (state_ff == CAPTURE_DR) begin
        bypass_ff <= 1'b0;
        id_shift_ff <= id_value;
      end else if (state_ff == SHIFT_DR) begin
        bypass_ff <= tap_sync_ff.tdi;
        id_shift_ff <= {tap_sync_ff.tdi, id_shift_ff[ID_WIDTH-1:1]};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Boundary-scan chain, cell 0 nearest tdo

  logic [NUM_CELLS-1:0] cell_so;
  logic [NUM_CELLS-1:0] cell_upd;
  logic [NUM_CELLS-1:0] cell_cap;
  logic [NUM_CELLS:0] chain;
  logic bsr_capture;
  logic bsr_shift;
  logic bsr_update;

  assign bsr_capture = step && bsr_sel && (state_ff == CAPTURE_DR);
  assign bsr_shift = step && bsr_sel && (state_ff == SHIFT_DR);
  assign bsr_update = step && bsr_sel && (state_ff == UPDATE_DR);
  assign chain[NUM_CELLS] = tap_sync_ff.tdi;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
      assign cell_cap[gi*CELLS_PER_PIN+CELL_IN] = pin_sync_ff[gi];
      assign cell_cap[gi*CELLS_PER_PIN+CELL_DATA] = core_out[gi];
      assign cell_cap[gi*CELLS_PER_PIN+CELL_CTRL] = core_oe[gi];
    end
    for (gi = 0; gi < NUM_CELLS; gi++) begin : g_cell
      scan_cell u_cell (
        .clk(clk),
        .reset_n(reset_n),
        .ce(ce),
        .capture_en(bsr_capture),
        .shift_en(bsr_shift),
        .update_en(bsr_update),
        .cap_val(cell_cap[gi]),
        .scan_in(chain[gi+1]),
        .scan_out(cell_so[gi]),
        .upd_out(cell_upd[gi])
      );
      assign chain[gi] = cell_so[gi];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Pin muxing, registered so pins never glitch on decode changes

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_out <= '0;
      pin_oe <= '0;
      core_in <= '0;
    end else if (ce) begin
      for (int i = 0; i < NUM_PINS; i++) begin
        if (mode_highz) begin
          pin_out[i] <= core_out[i];
          pin_oe[i] <= 1'b0;
        end else if (mode_drive) begin
          pin_out[i] <= cell_upd[i*CELLS_PER_PIN+CELL_DATA];
          pin_oe[i] <= cell_upd[i*CELLS_PER_PIN+CELL_CTRL];
        end else begin
          pin_out[i] <= core_out[i];
          pin_oe[i] <= core_oe[i];
        end
        core_in[i] <= mode_extest ? cell_upd[i*CELLS_PER_PIN+CELL_IN] : pin_sync_ff[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Test data out, changed on falling tck

  logic nxt_tdo;
  always_comb begin
    nxt_tdo = bypass_ff;
    if (state_ff == SHIFT_IR) begin
      nxt_tdo = ir_shift_ff[0];
    end else if (dr_sel == SEL_BOUNDARY) begin
      nxt_tdo = cell_so[0];
    end else if (dr_sel == SEL_IDCODE) begin
      nxt_tdo = id_shift_ff[0];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tdo <= 1'b0;
      tdo_oe <= 1'b0;
    end else if (ce) begin
      if (!tap_sync_ff.trst_n) begin
        tdo_oe <= 1'b0;
      end else if (tck_fall) begin
        tdo <= nxt_tdo;
        tdo_oe <= (state_ff == SHIFT_IR) || (state_ff == SHIFT_DR);
      end
    end
  end

endmodule : jtag_tap

// ==== hdl/tap_pkg.sv ====
/*
  Shared constants and types of the boundary-scan test access port:
  instruction codes, identification layout, state and carrier types.
  Assumes nothing beyond a SystemVerilog-2012 compiler.
*/
package tap_pkg;

  localparam int IR_WIDTH = 5;
  localparam logic [IR_WIDTH-1:0] OP_EXTEST = 5'h00;
  localparam logic [IR_WIDTH-1:0] OP_SAMPLE = 5'h01;
  localparam logic [IR_WIDTH-1:0] OP_INT_SCAN = 5'h02;
  localparam logic [IR_WIDTH-1:0] OP_CLAMP = 5'h04;
  localparam logic [IR_WIDTH-1:0] OP_HIGHZ = 5'h05;
  localparam logic [IR_WIDTH-1:0] OP_PRIVATE_PHY_TEST = 5'h09;
  localparam logic [IR_WIDTH-1:0] OP_MEMORY_SELF_TEST = 5'h0a;
  localparam logic [IR_WIDTH-1:0] OP_IDCODE = 5'h0c;
  localparam logic [IR_WIDTH-1:0] OP_BYPASS = 5'h1f;
  // Fixed pattern loaded in Capture-IR, low bits 01
  localparam logic [IR_WIDTH-1:0] IR_CAPTURE_VAL = 5'h01;
  localparam logic [IR_WIDTH-1:0] IR_RESET_VAL = OP_IDCODE;

  localparam int ID_WIDTH = 32;
  localparam int ID_VERSION_LSB = 28;
  localparam int ID_VERSION_W = 4;
  localparam int ID_PART_LSB = 12;
  localparam int ID_PART_W = 16;
  localparam int ID_MANUF_LSB = 1;
  localparam int ID_MANUF_W = 11;
  localparam logic ID_FIXED_BIT = 1'b1;

  // Scan cells per pin: input capture, output data, output enable
  localparam int CELLS_PER_PIN = 3;
  localparam int CELL_IN = 0;
  localparam int CELL_DATA = 1;
  localparam int CELL_CTRL = 2;

  localparam int TLR_TMS_ONES = 5;

  typedef enum logic [3:0] {
    TEST_LOGIC_RESET, RUN_TEST_IDLE,
    SELECT_DR, CAPTURE_DR, SHIFT_DR, EXIT1_DR, PAUSE_DR, EXIT2_DR, UPDATE_DR,
    SELECT_IR, CAPTURE_IR, SHIFT_IR, EXIT1_IR, PAUSE_IR, EXIT2_IR, UPDATE_IR
  } tap_state_e;

  typedef enum logic [1:0] {
    SEL_BYPASS, SEL_BOUNDARY, SEL_IDCODE
  } dr_sel_e;

  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
    logic trst_n;
  } tap_pins_s;

endpackage : tap_pkg

// ==== hdl/scan_cell.sv ====
/*
  One boundary-scan cell: a capture/shift stage and an update latch.
  Assumes strobes are single clk cycles already qualified by tck edges.
*/
`timescale 1ns/1ns
module scan_cell (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic capture_en,
  input wire logic shift_en,
  input wire logic update_en,
  input wire logic cap_val,
  input wire logic scan_in,
  output logic scan_out,
  output logic upd_out
);

  logic shift_ff;
  logic upd_ff;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      shift_ff <= 1'b0;
    end else if (ce) begin
      if (capture_en) begin
        shift_ff <= cap_val;
      end else if (shift_en) begin
        shift_ff <= scan_in;
      end
    end
  end

  // Update stage holds pins steady while new data shifts through
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      upd_ff <= 1'b0;
    end else if (ce && update_en) begin
      upd_ff <= shift_ff;
    end
  end

  assign scan_out = shift_ff;
  assign upd_out = upd_ff;

endmodule : scan_cell

// ==== tb/jtag_tester.sv ====
/*
  Tester model: drives tck, tms, tdi and trst_n and reads tdo.
  Assumes a free-running clk; every pin change lands on its falling edge.
*/
`timescale 1ns/1ns
module jtag_tester (
  input wire logic clk,
  input wire logic tdo,
  output logic tck,
  output logic tms,
  output logic tdi,
  output logic trst_n
);
  initial begin
    tck = 1'h0;
    tms = 1'h1;
    tdi = 1'h0;
    trst_n = 1'h1;
  end
  //////////////////////////////
  // One 80 ns tck cycle; tdo is read just before the rise
  task automatic step(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    repeat (4) @(negedge clk);
    o = tdo;
    tck = 1'h1;
    repeat (4) @(negedge clk);
    tck = 1'h0;
  endtask : step
  task automatic reset_tap();
    logic o;
    repeat (5) step(1'h1, tdi, o);
    step(1'h0, tdi, o);
  endtask : reset_tap
  // IR frames use the low five bits; tck stands still after the frame
  task automatic scan(input logic ir, input logic [31:0] din, output logic [31:0] dout);
    int n;
    logic o;
    n = ir ? 5 : 32;
    dout = '0;
    step(1'h1, tdi, o);
    if (ir) step(1'h1, tdi, o);
    step(1'h0, tdi, o);
    step(1'h0, tdi, o);
    for (int i = 0; i < n; i++) step(i == n - 1, din[i], dout[i]);
    step(1'h1, tdi, o);
    step(1'h0, tdi, o);
    // Idle data line shown as the inverse, never a stale copy
    tdi = ~tdi;
  endtask : scan
  task automatic pulse_trst();
    trst_n = 1'h0;
    repeat (8) @(negedge clk);
    trst_n = 1'h1;
    repeat (4) @(negedge clk);
  endtask : pulse_trst
endmodule : jtag_tester

// ==== tb/jtag_tap_properties.sv ====
/*
  Port timing checker of jtag_tap, bound to it.
  Assumes ce stays high and each tck phase spans four clk cycles.
*/
`timescale 1ns/1ns
module jtag_tap_properties #(
  parameter int NUM_PINS = 8
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic tck,
  input wire logic trst_n,
  input wire logic tdo,
  input wire logic tdo_oe,
  input wire logic [NUM_PINS-1:0] core_out,
  input wire logic [NUM_PINS-1:0] core_oe,
  input wire logic [NUM_PINS-1:0] pin_in,
  input wire logic [NUM_PINS-1:0] pin_out,
  input wire logic [NUM_PINS-1:0] pin_oe,
  input wire logic [NUM_PINS-1:0] core_in,
  input wire logic int_scan_en,
  input wire logic memory_self_test_en,
  input wire logic private_phy_test_en
);
  logic tck_ff;
  logic [3:0] rise_age_ff;
  logic [3:0] fall_age_ff;
  logic vend;
  assign vend = int_scan_en | memory_self_test_en | private_phy_test_en;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  //////////////////////////////
  // Ages since the last tck pin edge, saturating so idle time never wraps
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) tck_ff <= 1'h0;
    else tck_ff <= tck;
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) rise_age_ff <= 4'hf;
    else if (tck && !tck_ff) rise_age_ff <= 4'h0;
    else if (rise_age_ff != 4'hf) rise_age_ff <= rise_age_ff + 4'h1;
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) fall_age_ff <= 4'hf;
    else if (!tck && tck_ff) fall_age_ff <= 4'h0;
    else if (fall_age_ff != 4'hf) fall_age_ff <= fall_age_ff + 4'h1;
  end
  //////////////////////////////
  property p_tdo_at_fall;
    $changed(tdo) |-> fall_age_ff inside {[1:5]};
  endproperty
  a_tdo_at_fall: assert property (p_tdo_at_fall) else $error("tdo moved away from a tck fall");
  property p_oe_rise;
    $rose(tdo_oe) |-> fall_age_ff inside {[1:5]};
  endproperty
  a_oe_rise: assert property (p_oe_rise) else $error("tdo_oe rose away from a tck fall");
  property p_oe_fall;
    $fell(tdo_oe) |-> fall_age_ff inside {[1:5]} || !$past(trst_n, 2);
  endproperty
  a_oe_fall: assert property (p_oe_fall) else $error("tdo_oe fell with no tck fall or test reset");
  property p_trst_oe;
    !trst_n [*6] |-> !tdo_oe;
  endproperty
  a_trst_oe: assert property (p_trst_oe) else $error("tdo_oe still high under test reset");
  property p_vend_one;
    vend |-> $onehot({int_scan_en, memory_self_test_en, private_phy_test_en});
  endproperty
  a_vend_one: assert property (p_vend_one) else $error("two vendor modes at once");
  property p_vend_upd;
    $changed({int_scan_en, memory_self_test_en, private_phy_test_en}) |->
      rise_age_ff inside {[1:7]} || !$past(trst_n, 2);
  endproperty
  a_vend_upd: assert property (p_vend_upd) else $error("vendor mode changed off an update");
  property p_pass_out;
    vend && $past(vend) |-> pin_out == $past(core_out) && pin_oe == $past(core_oe);
  endproperty
  a_pass_out: assert property (p_pass_out) else $error("pins not following core in vendor mode");
  property p_pass_in;
    vend && $past(vend, 4) && $past(pin_in, 2) == $past(pin_in, 4) |-> core_in == $past(pin_in, 3);
  endproperty
  a_pass_in: assert property (p_pass_in) else $error("core_in not following pins in vendor mode");
endmodule : jtag_tap_properties

bind jtag_tap jtag_tap_properties #(.NUM_PINS(NUM_PINS)) u_props (.clk, .reset_n, .tck, .trst_n, .tdo,
  .tdo_oe, .core_out, .core_oe, .pin_in, .pin_out, .pin_oe, .core_in, .int_scan_en, .memory_self_test_en,
  .private_phy_test_en);

// ==== tb/test_jtag_tap.sv ====
/*
  Testbench of jtag_tap: instruction and data scans through the tester model.
  Assumes tap_pkg, jtag_tap, the tester and the checker are compiled first.
*/
`timescale 1ns/1ns
module test_jtag_tap
  import tap_pkg::*;
;
  localparam int NP = 8;
  localparam logic [3:0] VER = 4'h3; // Arbitrary value
  localparam logic [15:0] PART = 16'h5a6b; // Arbitrary value
  localparam logic [10:0] MANUF = 11'h2c5; // Arbitrary value
  localparam logic [31:0] IDV = {VER, PART, MANUF, ID_FIXED_BIT};
  localparam logic [23:0] P1 = 24'h9c36d1;
  localparam logic [23:0] P2 = 24'h4be217;
  localparam logic [31:0] D = 32'hc5a396e1;
  logic clk = 1'h0;
  logic reset_n = 1'h0;
  logic tck, tms, tdi, trst_n, tdo, tdo_oe, ise, mse, pte, ob;
  logic [NP-1:0] core_out = 8'ha5;
  logic [NP-1:0] core_oe = 8'h3c;
  logic [NP-1:0] pin_in = 8'h96;
  logic [NP-1:0] pin_out, pin_oe, core_in;
  logic [31:0] dout;
  int n_errors = 0;
  int n_tests = 0;
  always #5 clk = ~clk;
  jtag_tap #(.NUM_PINS(NP), .ID_VERSION(VER), .ID_PART(PART), .ID_MANUF(MANUF)) DUT (.clk, .reset_n,
    .ce(1'h1), .tck, .tms, .tdi, .trst_n, .tdo, .tdo_oe, .core_out, .core_oe, .pin_in, .pin_out, .pin_oe,
    .core_in, .int_scan_en(ise), .memory_self_test_en(mse), .private_phy_test_en(pte));
  jtag_tester tester (.clk, .tdo, .tck, .tms, .tdi, .trst_n);
  //////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      n_errors++;
    end
  endtask : chk
  function automatic logic [3*NP-1:0] cells(input logic [NP-1:0] i, input logic [NP-1:0] o,
    input logic [NP-1:0] e);
    for (int k = 0; k < NP; k++) cells[3*k +: 3] = {e[k], o[k], i[k]};
  endfunction : cells
  task automatic load_ir(input logic [4:0] code);
    tester.scan(1'h1, 32'(code), dout);
    chk("ir capture", 32'(IR_CAPTURE_VAL), dout);
  endtask : load_ir
  task automatic read_id(input string what);
    tester.scan(1'h0, 32'h0, dout);
    chk(what, IDV, dout);
  endtask : read_id
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : report_and_stop
  //////////////////////////////
  task automatic t_sample();
    load_ir(OP_SAMPLE);
    tester.scan(1'h0, {P1, 8'h7e}, dout);
    chk("sample capture", {8'h7e, cells(pin_in, core_out, core_oe)}, dout);
    chk("sample pins", 32'({pin_oe, pin_out, core_in}), 32'({core_oe, core_out, pin_in}));
  endtask : t_sample
  task automatic t_extest();
    load_ir(OP_EXTEST);
    chk("extest pins", 32'(P1), 32'(cells(core_in, pin_out, pin_oe)));
    pin_in = 8'h69;
    tester.scan(1'h0, {P2, 8'h00}, dout);
    chk("extest capture", {8'h00, cells(pin_in, core_out, core_oe)}, dout);
    chk("extest update", 32'(P2), 32'(cells(core_in, pin_out, pin_oe)));
  endtask : t_extest
  // Cells keep the last extest pattern, which clamp must drive
  task automatic t_bypass();
    logic [4:0] codes [9] = '{OP_BYPASS, OP_HIGHZ, OP_CLAMP, OP_INT_SCAN, OP_MEMORY_SELF_TEST,
      OP_PRIVATE_PHY_TEST, 5'h03, 5'h1e, 5'h10};
    logic [4:0] c;
    logic [NP-1:0] eo, ee;
    foreach (codes[j]) begin
      c = codes[j];
      pin_in = ~pin_in;
      load_ir(c);
      tester.scan(1'h0, D, dout);
      chk("bypass shift", {D[30:0], 1'h0}, dout);
      chk("vendor enables", 32'({ise, mse, pte}), 32'({c == 5'h02, c == 5'h0a, c == 5'h09}));
      for (int k = 0; k < NP; k++) begin
        eo[k] = (c == OP_CLAMP) ? P2[3*k+1] : core_out[k];
        ee[k] = (c == OP_CLAMP) ? P2[3*k+2] : (c != OP_HIGHZ) & core_oe[k];
      end
      chk("pin enable", 32'(ee), 32'(pin_oe));
      if (c != OP_HIGHZ) chk("pin data", 32'(eo), 32'(pin_out));
      chk("core input", 32'(pin_in), 32'(core_in));
    end
  endtask : t_bypass
  task automatic t_trst();
    load_ir(OP_BYPASS);
    tester.step(1'h1, 1'h0, ob);
    repeat (3) tester.step(1'h0, 1'h0, ob);
    chk("tdo enable in shift", 32'h1, 32'(tdo_oe));
    tester.pulse_trst();
    chk("tdo enable after test reset", 32'h0, 32'(tdo_oe));
    tester.reset_tap();
    read_id("idcode after test reset");
  endtask : t_trst
  //////////////////////////////
  initial begin
    repeat (20) @(negedge clk);
    reset_n = 1'h1;
    repeat (4) @(negedge clk);
    tester.reset_tap();
    read_id("idcode after power-up");
    t_sample();
    t_extest();
    t_bypass();
    load_ir(OP_BYPASS);
    tester.reset_tap();
    read_id("idcode after tms reset");
    t_trst();
    report_and_stop();
  end
  // Work is about 700 tck cycles (56 us); allow well over three times that
  initial begin
    #200000;
    n_errors++;
    report_and_stop();
  end
endmodule : test_jtag_tap
